//--- hdl/tnsf_pkg.sv
/*
 * Package for the token node status flag block.
 * Holds register offsets, bit positions, reset values, command codes and timing.
 * Assumes a 25 MHz APB clock and 32-bit APB data.
 */
package tnsf_pkg;
	// APB register byte offsets.
	localparam logic [7:0] TNSF_OFF_STATUS  = 8'h00; // Node status flags, read only.
	localparam logic [7:0] TNSF_OFF_MASK    = 8'h04; // Interrupt mask register.
	localparam logic [7:0] TNSF_OFF_CMD     = 8'h08; // Command register, write only.
	localparam logic [7:0] TNSF_OFF_STNID   = 8'h0C; // Station identifier register.
	localparam logic [7:0] TNSF_OFF_IRQSTAT = 8'h10; // Sticky interrupt status, W1C.
	// Status bit positions.
	localparam int TNSF_B_RXINH = 7; // Receive inhibited.
	localparam int TNSF_B_RST   = 4; // Reset occurred.
	localparam int TNSF_B_TEST  = 3; // Test bit.
	localparam int TNSF_B_RECON = 2; // Reconfiguration.
	localparam int TNSF_B_TXACK = 1; // Transmit acknowledged.
	localparam int TNSF_B_TXAV  = 0; // Transmitter available.
	// Bits that may raise an interrupt.
	localparam logic [7:0] TNSF_IRQ_BITS = 8'h85;
	// Reset values.
	localparam logic [7:0] TNSF_MASK_RST  = 8'h00;
	localparam logic [7:0] TNSF_STNID_RST = 8'h00;
	// Command codes, in bits 3:0 of the command write; page in bits 6:4.
	localparam logic [3:0] TNSF_CMD_TXDIS = 4'h1; // Transmitter disable.
	localparam logic [3:0] TNSF_CMD_TXEN  = 4'h3; // Transmit from page.
	localparam logic [3:0] TNSF_CMD_RXEN  = 4'h4; // Receive to page.
	localparam logic [3:0] TNSF_CMD_CLR   = 4'h6; // Flag clear.
	localparam logic [3:0] TNSF_CMD_SWRST = 4'h8; // Software reset.
	localparam logic [7:0] TNSF_ZERO8 = 8'h00;
	localparam logic [31:0] TNSF_ZERO32 = 32'h0000_0000;
	// Line idle time in nanoseconds and the clock rate.
	localparam int TNSF_IDLE_NS = 20500;
	localparam int TNSF_CLK_MHZ = 25;
	localparam int TNSF_IDLE_CYC = (TNSF_IDLE_NS * TNSF_CLK_MHZ) / 1000;
endpackage

//--- hdl/tnsf_idle_timer.sv
/*
 * Line idle timer for the token node status flag block.
 * Assumes the receive line input is synchronous to pclk.
 */
`timescale 1ns/10ps
`default_nettype none
module tnsf_idle_timer #(
	parameter int IDLE_CYC = 512
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic clk_en,
	input  wire logic line_active,
	output logic      expired
);
	logic [31:0] cnt_ff; // Idle cycles counted so far.

	// Counts idle cycles; restarts on activity; pulses once on reaching the limit.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 32'h0000_0000;
		end else if (clk_en) begin
			if (line_active) begin
				cnt_ff <= 32'h0000_0000;
			end else if (cnt_ff < IDLE_CYC) begin
				cnt_ff <= cnt_ff + 32'h0000_0001;
			end
		end
	end

	// The expiry pulse is high for the one cycle the count reaches its end.
	assign expired = clk_en && !line_active && (cnt_ff == (IDLE_CYC - 1));
endmodule
`default_nettype wire

//--- hdl/tnsf_top.sv
/*
 * Token node status flag register bank with APB slave and interrupt logic.
 * Assumes the rx and tx engines give one-cycle event pulses on pclk.
 */
`timescale 1ns/10ps
`default_nettype none
module tnsf_top
	import tnsf_pkg::*;
#(
	parameter int IDLE_CYC = tnsf_pkg::TNSF_IDLE_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	input  wire logic        line_receive_input,
	input  wire logic        rx_stored,
	input  wire logic        rx_request,
	output logic             rx_accept,
	output logic             rx_nak,
	input  wire logic        tx_acked_evt,
	input  wire logic        tx_broadcast,
	input  wire logic        tx_done,
	input  wire logic        token_rx,
	output logic             tx_go,
	output logic [2:0]       tx_page,
	output logic [2:0]       rx_page,
	output logic             irq
);
	import tnsf_pkg::*;

	logic       receive_inhibited_ff; // Receiver is not enabled.
	logic       rst_seen_ff;          // A reset has occurred.
	logic       recon_ff;             // Reconfiguration seen.
	logic       tx_acked_ff;          // Last transmit was acknowledged.
	logic       tx_available_ff;      // Transmitter free.
	logic       tx_pending_ff;        // Transmit enabled, waiting for the token.
	logic [7:0] irq_mask_reg_ff;      // Interrupt mask.
	logic [7:0] irq_stat_ff;          // Sticky interrupt status.
	logic [7:0] station_id_reg_ff;    // Station identifier.
	logic [2:0] rx_page_ff;           // Page named by last receive enable.
	logic [2:0] tx_page_ff;           // Page named by last transmit enable.
	logic [31:0] prdata_ff;           // Registered read data.
	logic        line_expired;        // Idle timer expiry pulse.
	logic [7:0]  node_status;         // Assembled status byte.
	logic [7:0]  nxt_irq_stat;        // Next sticky interrupt status.
	logic        wr_acc;              // APB write in its access phase.
	logic        rd_acc;              // APB read in its setup phase.
	logic        cmd_wr;              // Command register write.
	logic [3:0]  cmd_code;            // Command code field.
	logic        cmd_rxen;            // Receive enable command.
	logic        cmd_txen;            // Transmit enable command.
	logic        cmd_txdis;           // Transmitter disable command.
	logic        cmd_clr;             // Flag clear command.
	logic        cmd_swrst;           // Software reset command.
	logic        id_zero_wr;          // Zero written to the station id.
	logic        tx_start;            // Token taken with a transmit pending.

	// Returns true when the address matches a mapped register.
	function automatic logic tnsf_mapped(input logic [7:0] a);
		tnsf_mapped = (a == TNSF_OFF_STATUS) || (a == TNSF_OFF_MASK) ||
			(a == TNSF_OFF_CMD) || (a == TNSF_OFF_STNID) || (a == TNSF_OFF_IRQSTAT);
	endfunction

	// Line idle timer; any high level on the line counts as activity.
	tnsf_idle_timer #(
		.IDLE_CYC (IDLE_CYC)
	) u_idle (
		.pclk        (pclk),
		.presetn     (presetn),
		.clk_en      (clk_en),
		.line_active (line_receive_input),
		.expired     (line_expired)
	);

	// APB decode; the slave always answers in the access cycle.
	assign wr_acc   = psel && penable && pwrite && clk_en;
	assign rd_acc   = psel && !penable && !pwrite && clk_en;
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && !tnsf_mapped(paddr);
	assign cmd_wr   = wr_acc && (paddr == TNSF_OFF_CMD);
	assign cmd_code = pwdata[3:0];
	assign cmd_rxen  = cmd_wr && (cmd_code == TNSF_CMD_RXEN);
	assign cmd_txen  = cmd_wr && (cmd_code == TNSF_CMD_TXEN);
	assign cmd_txdis = cmd_wr && (cmd_code == TNSF_CMD_TXDIS);
	assign cmd_clr   = cmd_wr && (cmd_code == TNSF_CMD_CLR);
	assign cmd_swrst = cmd_wr && (cmd_code == TNSF_CMD_SWRST);
	assign id_zero_wr = wr_acc && (paddr == TNSF_OFF_STNID) && (pwdata[7:0] == TNSF_ZERO8);
	assign tx_start  = clk_en && token_rx && tx_pending_ff;

	// Status byte: bits six, five and three read zero.
	always_comb begin
		node_status = TNSF_ZERO8;
		node_status[TNSF_B_RXINH] = receive_inhibited_ff;
		node_status[TNSF_B_RST]   = rst_seen_ff;
		node_status[TNSF_B_RECON] = recon_ff;
		node_status[TNSF_B_TXACK] = tx_acked_ff;
		node_status[TNSF_B_TXAV]  = tx_available_ff;
	end

	// Receive inhibit; a stored packet sets it and wins over a same-cycle enable.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			receive_inhibited_ff <= 1'b1;
			rx_page_ff <= 3'h0;
		end else if (clk_en) begin
			if (cmd_swrst) begin
				receive_inhibited_ff <= 1'b1;
			end else if (rx_stored && !receive_inhibited_ff) begin
				receive_inhibited_ff <= 1'b1;
			end else if (cmd_rxen) begin
				receive_inhibited_ff <= 1'b0;
				rx_page_ff <= pwdata[6:4];
			end
		end
	end

	// The receiver accepts only while enabled, otherwise it NAKs.
	assign rx_accept = rx_request && !receive_inhibited_ff;
	assign rx_nak    = rx_request && receive_inhibited_ff;
	assign rx_page   = rx_page_ff;

	// Reset-occurred flag; set events win over the clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_seen_ff <= 1'b1;
		end else if (clk_en) begin
			if (cmd_swrst || id_zero_wr) begin
				rst_seen_ff <= 1'b1;
			end else if (cmd_clr) begin
				rst_seen_ff <= 1'b0;
			end
		end
	end

	// Reconfiguration flag; timer expiry wins over the clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			recon_ff <= 1'b0;
		end else if (clk_en) begin
			if (line_expired) begin
				recon_ff <= 1'b1;
			end else if (cmd_clr || cmd_swrst) begin
				recon_ff <= 1'b0;
			end
		end
	end

	// Transmit acknowledged flag; broadcast acknowledgements are ignored.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_acked_ff <= 1'b0;
		end else if (clk_en) begin
			if (tx_acked_evt && !tx_broadcast) begin
				tx_acked_ff <= 1'b1;
			end else if (cmd_txen || cmd_swrst) begin
				tx_acked_ff <= 1'b0;
			end
		end
	end

	// Transmitter available; cleared only when the token arrives after enable.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_available_ff <= 1'b1;
			tx_pending_ff   <= 1'b0;
			tx_page_ff      <= 3'h0;
		end else if (clk_en) begin
			if (tx_done || cmd_txdis || cmd_swrst) begin
				tx_available_ff <= 1'b1;
				tx_pending_ff   <= 1'b0;
			end else if (cmd_txen) begin
				tx_pending_ff <= 1'b1;
				tx_page_ff    <= pwdata[6:4];
			end else if (tx_start) begin
				tx_available_ff <= 1'b0;
				tx_pending_ff   <= 1'b0;
			end
		end
	end

	// Transmit start pulse to the transmit engine.
	assign tx_go   = tx_start;
	assign tx_page = tx_page_ff;

	// Station id register; a write of zero marks a reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			station_id_reg_ff <= TNSF_STNID_RST;
		end else if (wr_acc && (paddr == TNSF_OFF_STNID)) begin
			station_id_reg_ff <= pwdata[7:0];
		end
	end

	// Interrupt mask register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_reg_ff <= TNSF_MASK_RST;
		end else if (wr_acc && (paddr == TNSF_OFF_MASK)) begin
			irq_mask_reg_ff <= pwdata[7:0] & TNSF_IRQ_BITS;
		end
	end

	// Sticky status follows the flag levels; write one clears, set wins.
	always_comb begin
		nxt_irq_stat = irq_stat_ff;
		if (wr_acc && (paddr == TNSF_OFF_IRQSTAT)) begin
			nxt_irq_stat = nxt_irq_stat & ~pwdata[7:0];
		end
		nxt_irq_stat = nxt_irq_stat | (node_status & TNSF_IRQ_BITS);
	end

	// Sticky interrupt status register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_ff <= TNSF_ZERO8;
		end else if (clk_en) begin
			irq_stat_ff <= nxt_irq_stat;
		end
	end

	// Level interrupt while any unmasked sticky bit is set.
	assign irq = |(irq_stat_ff & irq_mask_reg_ff);

	// Read data is captured at the setup edge, so the flop already holds it
	// during the access phase; reads have no side effect.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= TNSF_ZERO32;
		end else if (rd_acc) begin
			case (paddr)
				TNSF_OFF_STATUS:  prdata_ff <= {24'h000000, node_status};
				TNSF_OFF_MASK:    prdata_ff <= {24'h000000, irq_mask_reg_ff};
				TNSF_OFF_STNID:   prdata_ff <= {24'h000000, station_id_reg_ff};
				TNSF_OFF_IRQSTAT: prdata_ff <= {24'h000000, irq_stat_ff};
				default:          prdata_ff <= TNSF_ZERO32;
			endcase
		end
	end

	// Read data from the flop, valid throughout the access phase.
	always_comb begin
		prdata = prdata_ff;
	end
endmodule
`default_nettype wire

//--- verif/tnsf_monitor.sv
/* Port checker for tnsf_top.
   Assumes it is bound to every tnsf_top instance. */
`timescale 1ns/10ps
`default_nettype none
module tnsf_monitor
	import tnsf_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] prdata,
	input wire logic        rx_request,
	input wire logic        rx_accept,
	input wire logic        rx_nak,
	input wire logic        token_rx,
	input wire logic        tx_go,
	input wire logic        irq
);
	logic acc; // Access phase of a transfer.
	logic unm; // Address outside the register map.
	assign acc = psel && penable;
	assign unm = !(paddr inside {TNSF_OFF_STATUS, TNSF_OFF_MASK, TNSF_OFF_CMD,
		TNSF_OFF_STNID, TNSF_OFF_IRQSTAT});
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// A read access to the status word.
	sequence s_rd_st;
		acc && !pwrite && paddr == TNSF_OFF_STATUS;
	endsequence
	property p_ready;
		acc |-> pready;
	endproperty
	property p_slverr;
		acc && unm |-> pslverr;
	endproperty
	// Reserved status bits read zero during a status read access phase.
	property p_rdz;
		s_rd_st |-> prdata[31:8] == 24'h0 && prdata[6:5] == 2'h0 && !prdata[3];
	endproperty
	property p_unm;
		acc && !pwrite && unm |-> prdata == TNSF_ZERO32;
	endproperty
	property p_nak;
		rx_nak |-> rx_request && !rx_accept;
	endproperty
	property p_answer;
		rx_request |-> rx_accept ^ rx_nak;
	endproperty
	property p_go;
		tx_go |-> token_rx;
	endproperty
	// The mask is clear after reset, so no interrupt can stand.
	property p_irq;
		$rose(presetn) |-> !irq ##1 !irq;
	endproperty
	a_ready: assert property (p_ready) else $error("pready low in access");
	a_slverr: assert property (p_slverr) else $error("no error on unmapped");
	a_rdz: assert property (p_rdz) else $error("reserved status bits set");
	a_unm: assert property (p_unm) else $error("unmapped read not zero");
	a_nak: assert property (p_nak) else $error("stray negative answer");
	a_answer: assert property (p_answer) else $error("sender not answered");
	a_go: assert property (p_go) else $error("transmit without token");
	a_irq: assert property (p_irq) else $error("interrupt after reset");
endmodule
bind tnsf_top tnsf_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
	.pslverr(pslverr), .prdata(prdata), .rx_request(rx_request),
	.rx_accept(rx_accept), .rx_nak(rx_nak), .token_rx(token_rx),
	.tx_go(tx_go), .irq(irq));
`default_nettype wire

//--- verif/tnsf_engine_model.sv
/* Model of the receive and transmit engines beside the flag block.
   Assumes the bench calls its tasks; all changes follow a pclk edge. */
`timescale 1ns/10ps
`default_nettype none
module tnsf_engine_model (
	input  wire logic pclk,
	input  wire logic tx_go,
	output logic      line_receive_input,
	output logic      rx_request,
	output logic      tx_broadcast,
	output logic      rx_stored,
	output logic      tx_acked_evt,
	output logic      tx_done,
	output logic      token_rx,
	output logic      go_seen
);
	logic [3:0] ev = 4'h0; // One-cycle event pulses.
	assign {token_rx, tx_done, tx_acked_evt, rx_stored} = ev;
	// The line starts busy so the idle timer stays quiet.
	initial begin
		{line_receive_input, rx_request, tx_broadcast, go_seen} = 4'h8;
	end
	// Remembers whether the last token started a transmission.
	always @(posedge pclk) begin
		if (token_rx) go_seen <= tx_go;
	end
	// Pulses the chosen events for exactly one cycle.
	task automatic pulse(input logic [3:0] m);
		@(posedge pclk);
		ev <= m;
		@(posedge pclk);
		ev <= 4'h0;
	endtask
	// Sets the request and broadcast levels.
	task automatic lv(input logic rq, input logic bc);
		@(posedge pclk);
		rx_request <= rq;
		tx_broadcast <= bc;
	endtask
	// Holds the line silent for n cycles.
	task automatic idle(input int n);
		@(posedge pclk);
		line_receive_input <= 1'b0;
		repeat (n) @(posedge pclk);
		line_receive_input <= 1'b1;
	endtask
endmodule
`default_nettype wire

//--- verif/test_token_node_status_flags.sv
/* Self-checking bench for tnsf_top over APB.
   Assumes the engine model and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module test_token_node_status_flags;
	import tnsf_pkg::*;
	localparam int IDLE = 16; // Short idle count for simulation.
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, v;
	logic        line_in, rx_stored, rx_request, tx_acked_evt, tx_broadcast;
	logic        tx_done, token_rx, rx_accept, rx_nak, tx_go, irq, go_seen;
	logic        clk_en; // Bench-driven clock enable.
	logic [2:0]  tx_page, rx_page;
	int          n_fail, checks_done;
	tnsf_top #(.IDLE_CYC(IDLE)) dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.line_receive_input(line_in), .rx_stored(rx_stored), .rx_request(rx_request),
		.rx_accept(rx_accept), .rx_nak(rx_nak), .tx_acked_evt(tx_acked_evt),
		.tx_broadcast(tx_broadcast), .tx_done(tx_done), .token_rx(token_rx),
		.tx_go(tx_go), .tx_page(tx_page), .rx_page(rx_page), .irq(irq));
	tnsf_engine_model eng (.pclk(pclk), .tx_go(tx_go), .line_receive_input(line_in),
		.rx_request(rx_request), .tx_broadcast(tx_broadcast), .rx_stored(rx_stored),
		.tx_acked_evt(tx_acked_evt), .tx_done(tx_done), .token_rx(token_rx),
		.go_seen(go_seen));
	always #20 pclk = ~pclk;
	// One APB transfer; read data is taken at the edge where pready is seen high.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		v = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
		xfer(1'b0, a, TNSF_ZERO32);
		chk(n, e, v);
	endtask
	task automatic st(input logic [7:0] e);
		rdc(TNSF_OFF_STATUS, {24'h0, e}, "status");
	endtask
	task automatic cmd(input logic [2:0] pg, input logic [3:0] c);
		wr(TNSF_OFF_CMD, {25'h0, pg, c});
	endtask
	task automatic tally_and_finish;
		if (n_fail == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Cuts a hang short.
	initial begin
		repeat (3000) @(posedge pclk);
		n_fail++;
		tally_and_finish;
	end
	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		clk_en = 1'b1;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		st(8'h91);
		st(8'h91);
		rdc(TNSF_OFF_MASK, TNSF_ZERO32, "mask");
		cmd(3'h0, TNSF_CMD_CLR);
		st(8'h81);
		cmd(3'h2, TNSF_CMD_RXEN);
		st(8'h01);
		chk("rx_page", 32'h2, 32'(rx_page));
		eng.lv(1'b1, 1'b0);
		@(posedge pclk);
		chk("rx_accept", 32'h1, 32'(rx_accept));
		eng.pulse(4'h1);
		st(8'h81);
		chk("rx_nak", 32'h1, 32'(rx_nak));
		cmd(3'h3, TNSF_CMD_TXEN);
		chk("tx_page", 32'h3, 32'(tx_page));
		st(8'h81);
		eng.pulse(4'h8);
		st(8'h80);
		eng.pulse(4'h6);
		st(8'h83);
		cmd(3'h3, TNSF_CMD_TXEN);
		st(8'h81);
		eng.pulse(4'h8);
		@(posedge pclk);
		chk("go", 32'h1, 32'(go_seen));
		eng.lv(1'b1, 1'b1);
		eng.pulse(4'h2);
		cmd(3'h0, TNSF_CMD_TXDIS);
		st(8'h81);
		wr(TNSF_OFF_MASK, 32'hFF);
		rdc(TNSF_OFF_MASK, 32'h85, "mask");
		wr(TNSF_OFF_MASK, 32'h04);
		eng.idle(IDLE - 2);
		st(8'h81);
		eng.idle(IDLE + 4);
		st(8'h85);
		chk("irq", 32'h1, 32'(irq));
		rdc(TNSF_OFF_IRQSTAT, 32'h85, "irq_status");
		wr(TNSF_OFF_MASK, 32'h00);
		chk("irq", 32'h0, 32'(irq));
		cmd(3'h0, TNSF_CMD_CLR);
		st(8'h81);
		wr(TNSF_OFF_IRQSTAT, 32'h04);
		wr(TNSF_OFF_MASK, 32'h04);
		chk("irq", 32'h0, 32'(irq));
		wr(TNSF_OFF_STNID, 32'h05);
		st(8'h81);
		wr(TNSF_OFF_STNID, 32'h00);
		wr(TNSF_OFF_STATUS, 32'h00);
		st(8'h91);
		rdc(8'h14, TNSF_ZERO32, "unmapped");
		cmd(3'h0, TNSF_CMD_CLR);
		cmd(3'h0, TNSF_CMD_SWRST);
		st(8'h91);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		st(8'h91);
		@(posedge pclk);
		clk_en <= 1'b0;
		cmd(3'h0, TNSF_CMD_CLR);
		clk_en <= 1'b1;
		st(8'h91);
		cmd(3'h0, TNSF_CMD_CLR);
		st(8'h81);
		tally_and_finish;
	end
endmodule
`default_nettype wire
